// file: design/agc_tc_pkg.sv
/*
 agc_tc_pkg: register map, field layout, reset values and timing constants
 for the agc time-constant register bank.
 assumes: a 200 MHz aclk and a 32-bit axi4-lite register bus.
*/
package agc_tc_pkg;
   // register indices as printed; byte address is four times the index
   localparam logic [7:0] IDX_DECAY = 8'h68;
   localparam logic [7:0] IDX_ATTACK = 8'h69;
   localparam logic [7:0] IDX_CTRL = 8'h6a;
   localparam logic [11:0] ADDR_DECAY = {2'h0, IDX_DECAY, 2'h0};
   localparam logic [11:0] ADDR_ATTACK = {2'h0, IDX_ATTACK, 2'h0};
   localparam logic [11:0] ADDR_CTRL = {2'h0, IDX_CTRL, 2'h0};
   localparam int ADDR_W = 12;

   // field positions
   localparam int SEL_BIT = 7;
   localparam int BASE_HI = 6;
   localparam int BASE_LO = 5;
   localparam int MULT_HI = 4;
   localparam int MULT_LO = 2;
   localparam logic [7:0] REG_RST = 8'h00;
   localparam logic [7:0] WR_MASK = 8'hfc; // low two bits stay zero
   localparam logic [3:0] RATIO_RST = 4'h0;

   // baseline times in ms
   localparam int DECAY_MS_0 = 50;
   localparam int DECAY_MS_1 = 150;
   localparam int DECAY_MS_2 = 250;
   localparam int DECAY_MS_3 = 350;
   localparam int ATTACK_MS_0 = 7;
   localparam int ATTACK_MS_1 = 8;
   localparam int ATTACK_MS_2 = 10;
   localparam int ATTACK_MS_3 = 11;

   // decay caps in ms per decimation ratio code (ratio = 1 + code/2)
   localparam int CAP_MS_R10 = 4000;
   localparam int CAP_MS_R15 = 5600;
   localparam int CAP_MS_R20 = 8000;
   localparam int CAP_MS_R25 = 9600;
   localparam int CAP_MS_R35 = 11200;
   localparam int CAP_MS_R45 = 16000;
   localparam int CAP_MS_R50 = 19200;
   localparam int CAP_MS_R60 = 22400;
   localparam int TIME_W = 16;

   // clock and millisecond tick
   localparam int CLK_MHZ = 200;
   localparam int MS_PER_TICK = 1;
   localparam int TICK_CYCLES = MS_PER_TICK * CLK_MHZ * 1000;
   localparam int TICK_W = 18;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : agc_tc_pkg

// file: design/agc_time_constant_regs.sv
/*
 agc_time_constant_regs: left decay and right attack time-constant
 registers with an axi4-lite slave, the time-constant arithmetic and a
 millisecond tick for the agc engine.
 assumes: one master with at most one write and one read outstanding;
 legacy times come from same-clock logic; the decimation ratio is written at ADDR_CTRL.
*/
// Contract
// - left decay select: 0 legacy, 1 new
// - decay baseline codes give 50/150/250/350 ms
// - decay multiplier scales by two to field
// - decay capped by decimation ratio, 4..22.4 s
// - right attack select: 0 legacy, 1 new
// - attack baseline codes give 7/8/10/11 ms
// - attack multiplier scales 1 to 128
module agc_time_constant_regs
   import agc_tc_pkg::*;
#(
   parameter int TICK_COUNT = TICK_CYCLES
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [agc_tc_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [agc_tc_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [agc_tc_pkg::TIME_W-1:0] legacy_decay_ms,
   input wire logic [agc_tc_pkg::TIME_W-1:0] legacy_attack_ms,
   output logic [agc_tc_pkg::TIME_W-1:0] left_decay_ms_q,
   output logic [agc_tc_pkg::TIME_W-1:0] right_attack_ms_q,
   output logic ms_tick_q
);
   import agc_tc_pkg::*;

   typedef enum logic [2:0]
   {
      WR_IDLE = 3'b001,
      WR_RESP = 3'b010,
      WR_HOLD = 3'b100
   } wr_state_t;

   wr_state_t wr_state_q;
   logic aw_have_q;
   logic w_have_q;
   logic [ADDR_W-1:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic [7:0] decay_reg_q;
   logic [7:0] attack_reg_q;
   logic [3:0] adc_decimation_ratio_q;
   logic [TIME_W-1:0] decay_new_d;
   logic [TIME_W-1:0] attack_new_d;
   logic [TIME_W-1:0] decay_cap_d;
   logic [TICK_W-1:0] tick_cnt_q;
   logic wr_fire;

   // baseline lookup shared by both channels
   function automatic logic [TIME_W-1:0] base_ms(input logic [1:0] code,
                                                 input logic decay);
      logic [TIME_W-1:0] r;
      r = '0;
      case (code)
         2'h0: r = decay ? TIME_W'(DECAY_MS_0) : TIME_W'(ATTACK_MS_0);
         2'h1: r = decay ? TIME_W'(DECAY_MS_1) : TIME_W'(ATTACK_MS_1);
         2'h2: r = decay ? TIME_W'(DECAY_MS_2) : TIME_W'(ATTACK_MS_2);
         default: r = decay ? TIME_W'(DECAY_MS_3) : TIME_W'(ATTACK_MS_3);
      endcase
      return r;
   endfunction : base_ms

   // baseline shifted by the multiplier; 350 ms x 128 fits 16 bits
   function automatic logic [TIME_W-1:0] scaled(input logic [7:0] rv,
                                               input logic decay);
      return base_ms(rv[BASE_HI:BASE_LO], decay) << rv[MULT_HI:MULT_LO];
   endfunction : scaled

   // register read decode, used by the read channel
   function automatic logic [31:0] read_word(input logic [ADDR_W-1:0] a,
                                            input logic [7:0] d,
                                            input logic [7:0] t,
                                            input logic [3:0] r);
      logic [31:0] v;
      v = 32'h0;
      case (a)
         ADDR_DECAY: v = {24'h0, d};
         ADDR_ATTACK: v = {24'h0, t};
         ADDR_CTRL: v = {28'h0, r};
         default: v = 32'h0;
      endcase
      return v;
   endfunction : read_word

   function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
      return (a == ADDR_DECAY) || (a == ADDR_ATTACK) || (a == ADDR_CTRL);
   endfunction : is_mapped

   // write channel: address and data taken in either order
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_have_q <= 1'b0;
         aw_addr_q <= '0;
      end
      else if (s_axi_awvalid && s_axi_awready)
      begin
         aw_have_q <= 1'b1;
         aw_addr_q <= s_axi_awaddr;
      end
      else if (wr_fire)
      begin
         aw_have_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_have_q <= 1'b0;
         w_data_q <= 32'h0;
         w_strb_q <= 4'h0;
      end
      else if (s_axi_wvalid && s_axi_wready)
      begin
         w_have_q <= 1'b1;
         w_data_q <= s_axi_wdata;
         w_strb_q <= s_axi_wstrb;
      end
      else if (wr_fire)
      begin
         w_have_q <= 1'b0;
      end
   end

   // ready drops once a beat is held so a second write cannot overtake
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end
      else
      begin
         s_axi_awready <= wr_state_q == WR_IDLE && !aw_have_q &&
                          !(s_axi_awvalid && s_axi_awready);
         s_axi_wready <= wr_state_q == WR_IDLE && !w_have_q &&
                         !(s_axi_wvalid && s_axi_wready);
      end
   end

   assign wr_fire = wr_state_q == WR_IDLE && aw_have_q && w_have_q;

   // write response sequencing
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wr_state_q <= WR_IDLE;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end
      else
      begin
         case (wr_state_q)
            WR_IDLE:
            begin
               if (wr_fire)
               begin
                  s_axi_bvalid <= 1'b1;
                  s_axi_bresp <= is_mapped(aw_addr_q) ? RESP_OKAY
                                                      : RESP_SLVERR;
                  wr_state_q <= WR_RESP;
               end
            end
            WR_RESP:
            begin
               if (s_axi_bready)
               begin
                  s_axi_bvalid <= 1'b0;
                  wr_state_q <= WR_HOLD;
               end
            end
            WR_HOLD: wr_state_q <= WR_IDLE; // lets ready settle
            default: wr_state_q <= WR_IDLE;
         endcase
      end
   end

   // register storage; decay and attack bits 1:0 are forced to zero whatever is written
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         decay_reg_q <= REG_RST;
         attack_reg_q <= REG_RST;
         adc_decimation_ratio_q <= RATIO_RST;
      end
      else if (wr_fire && w_strb_q[0])
      begin
         if (aw_addr_q == ADDR_DECAY)
            decay_reg_q <= w_data_q[7:0] & WR_MASK;
         if (aw_addr_q == ADDR_ATTACK)
            attack_reg_q <= w_data_q[7:0] & WR_MASK;
         if (aw_addr_q == ADDR_CTRL)
            adc_decimation_ratio_q <= w_data_q[3:0];
      end
   end

   // read channel: one-cycle latency after the address is taken
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= RESP_OKAY;
      end
      else if (s_axi_rvalid)
      begin
         if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b0;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= read_word(s_axi_araddr, decay_reg_q, attack_reg_q,
                                  adc_decimation_ratio_q);
         s_axi_rresp <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end
      else
      begin
         s_axi_arready <= 1'b1;
      end
   end

   // decay cap per decimation ratio; codes above 10 read as ratio 6
   always_comb
   begin
      case (adc_decimation_ratio_q)
         4'h0: decay_cap_d = TIME_W'(CAP_MS_R10);
         4'h1: decay_cap_d = TIME_W'(CAP_MS_R15);
         4'h2: decay_cap_d = TIME_W'(CAP_MS_R20);
         4'h3: decay_cap_d = TIME_W'(CAP_MS_R25);
         4'h4, 4'h5: decay_cap_d = TIME_W'(CAP_MS_R35);
         4'h6, 4'h7: decay_cap_d = TIME_W'(CAP_MS_R45);
         4'h8: decay_cap_d = TIME_W'(CAP_MS_R50);
         default: decay_cap_d = TIME_W'(CAP_MS_R60);
      endcase
   end

   // new-register times: baseline shifted by the multiplier
   always_comb
   begin
      decay_new_d = scaled(decay_reg_q, 1'b1);
      attack_new_d = scaled(attack_reg_q, 1'b0);
   end

   // select source and apply the cap; cap applies to legacy too
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         left_decay_ms_q <= '0;
         right_attack_ms_q <= '0;
      end
      else
      begin
         if (decay_reg_q[SEL_BIT])
            left_decay_ms_q <= (decay_new_d > decay_cap_d) ? decay_cap_d
                                                           : decay_new_d;
         else
            left_decay_ms_q <= (legacy_decay_ms > decay_cap_d)
                               ? decay_cap_d : legacy_decay_ms;
         right_attack_ms_q <= attack_reg_q[SEL_BIT] ? attack_new_d
                                                    : legacy_attack_ms;
      end
   end

   // millisecond tick so the engine can count the times above
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         tick_cnt_q <= '0;
         ms_tick_q <= 1'b0;
      end
      else if (tick_cnt_q == TICK_W'(TICK_COUNT - 1))
      begin
         tick_cnt_q <= '0;
         ms_tick_q <= 1'b1;
      end
      else
      begin
         tick_cnt_q <= tick_cnt_q + 1'b1;
         ms_tick_q <= 1'b0;
      end
   end
endmodule : agc_time_constant_regs

// file: verification/agc_tc_chk.sv
/*
 agc_tc_chk: bus handshake and time-output assertions for the agc
 time-constant register bank.
 assumes: bound to agc_time_constant_regs, one clock, sync active-low reset.
*/
module agc_tc_chk
   import agc_tc_pkg::*;
#(
   parameter int TICK_COUNT = 4
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [agc_tc_pkg::TIME_W-1:0] left_decay_ms_q,
   input wire logic ms_tick_q
);
   int gap_q;
   logic seen_q;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // cycles since the last tick; the first tick after reset only arms it
   always_ff @(posedge aclk)
   begin
      if (!aresetn || ms_tick_q)
         gap_q <= 0;
      else
         gap_q <= gap_q + 1;
      seen_q <= aresetn && (seen_q || ms_tick_q);
   end
   chk_tick_gap: assert property (ms_tick_q && seen_q |-> gap_q == TICK_COUNT-1)
      else $error("tick spacing wrong");
   chk_decay_cap: assert property (left_decay_ms_q <= 16'h5780)
      else $error("decay above the largest cap");
   chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped early");
   chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("r dropped early");
   chk_b_after_w: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
      else $error("write response late");
   chk_r_after_ar: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid) else $error("read data late");
   chk_aw_busy: assert property (s_axi_bvalid
      |-> !s_axi_awready && !s_axi_wready) else $error("write taken early");
   chk_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken early");
endmodule : agc_tc_chk

bind agc_time_constant_regs agc_tc_chk #(.TICK_COUNT(TICK_COUNT)) i_chk (
   .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
   .left_decay_ms_q, .ms_tick_q);

// file: verification/agc_time_constant_regs_bench.sv
/*
 agc_time_constant_regs_bench: axi4-lite master, noted expectations and
 an answer watcher for the agc time-constant register bank.
 assumes: the checker is bound in; tick count shortened to 4 cycles.
*/
module agc_time_constant_regs_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import agc_tc_pkg::*;
   logic aclk = 1'b0, aresetn = 1'b0, probe = 1'b0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, seed = 32'h47;
   logic [3:0] s_axi_wstrb = '0;
   logic [15:0] legacy_decay_ms = '0, legacy_attack_ms = '0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, ms_tick_q;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [15:0] left_decay_ms_q, right_attack_ms_q;
   logic [31:0] exp_q[$];
   int errors = 0, tests_run = 0;
   int dbase[4] = '{50, 150, 250, 350};
   int abase[4] = '{7, 8, 10, 11};

   agc_time_constant_regs #(.TICK_COUNT(4)) i_dut (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .legacy_decay_ms, .legacy_attack_ms, .left_decay_ms_q,
      .right_attack_ms_q, .ms_tick_q);

   initial forever #2.5 aclk = ~aclk;

   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   // expected decay: chosen source, then the cap of the decimation ratio
   function automatic logic [15:0] tdec(logic [7:0] r, logic [15:0] lg,
                                        logic [3:0] c);
      int caps[11] = '{4000, 5600, 8000, 9600, 11200, 11200, 16000, 16000,
                       19200, 22400, 22400};
      int t;
      int cap;
      t = r[7] ? dbase[r[6:5]] << r[4:2] : lg;
      cap = (c > 4'ha) ? 22400 : caps[c];
      t = (t > cap) ? cap : t;
      return t[15:0];
   endfunction : tdec

   function automatic logic [15:0] tatt(logic [7:0] r, logic [15:0] lg);
      int t;
      t = r[7] ? abase[r[6:5]] << r[4:2] : lg;
      return t[15:0];
   endfunction : tatt

   task finish_test();
      if (errors == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : finish_test

   task automatic cmp(input logic [31:0] got);
      logic [31:0] e;
      e = exp_q.size() ? exp_q.pop_front() : 32'hx;
      tests_run++;
      if (got !== e)
      begin
         errors++;
         $display("BAD t=%0t exp=%h got=%h", $time, e, got);
      end
   endtask : cmp

   // the watcher takes the oldest note whenever an answer shows
   always @(posedge aclk)
   begin
      if (s_axi_bvalid && s_axi_bready) cmp({30'h0, s_axi_bresp});
      // read data first, then its response code, as rd notes them
      if (s_axi_rvalid && s_axi_rready)
      begin
         cmp(s_axi_rdata);
         cmp({30'h0, s_axi_rresp});
      end
      if (probe) cmp({left_decay_ms_q, right_attack_ms_q});
   end

   // trailing edge keeps the next call from driving in the same step
   task automatic wr(input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] st, input logic [1:0] rsp);
      logic aw = 1'b0;
      logic w = 1'b0;
      exp_q.push_back({30'h0, rsp});
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= st;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw && w))
      begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) aw = 1'b1;
         if (s_axi_wvalid && s_axi_wready) w = 1'b1;
         s_axi_awvalid <= !aw;
         s_axi_wvalid <= !w;
      end
      do @(posedge aclk); while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask : wr

   // unmapped offsets must answer with a slave error
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      exp_q.push_back({30'h0, ((a == ADDR_DECAY || a == ADDR_ATTACK ||
                       a == ADDR_CTRL) ? RESP_OKAY : RESP_SLVERR)});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask : rd

   task automatic pr(input logic [31:0] e);
      exp_q.push_back(e);
      probe <= 1'b1;
      @(posedge aclk);
      probe <= 1'b0;
      @(posedge aclk);
   endtask : pr

   initial
   begin
      logic [7:0] dr, ar;
      logic [15:0] ld, la;
      logic [31:0] r32;
      logic [3:0] c;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd(ADDR_DECAY, 32'h0);
      rd(ADDR_ATTACK, 32'h0);
      rd(ADDR_CTRL, 32'h0);
      pr(32'h0);
      // every decay baseline and multiplier code, every ratio code, then random
      for (int i = 0; i < 48; i++)
      begin
         {dr, ar, ld} = rnd();
         r32 = rnd();
         la = r32[15:0];
         c = r32[19:16];
         if (i < 32) dr[7:2] = {1'b1, i[1:0], i[4:2]};
         if (i < 32) c = i[3:0];
         dr[1:0] = 2'h0;
         ar[1:0] = 2'h0;
         legacy_decay_ms <= ld;
         legacy_attack_ms <= la;
         wr(ADDR_CTRL, {28'h0, c}, 4'hf, RESP_OKAY);
         wr(ADDR_DECAY, {24'h0, dr}, 4'hf, RESP_OKAY);
         wr(ADDR_ATTACK, {24'h0, ar}, 4'hf, RESP_OKAY);
         rd(ADDR_DECAY, {24'h0, dr});
         rd(ADDR_ATTACK, {24'h0, ar});
         rd(ADDR_CTRL, {28'h0, c});
         pr({tdec(dr, ld, c), tatt(ar, la)});
      end
      // refused and strobe-less writes leave the decay register untouched; a full-strobe write then lands
      wr(12'h0, 32'hff, 4'hf, RESP_SLVERR);
      rd(12'h0, 32'h0);
      wr(ADDR_DECAY, 32'hffff_fffc, 4'h0, RESP_OKAY);
      rd(ADDR_DECAY, {24'h0, dr});
      wr(ADDR_DECAY, 32'hffff_fffc, 4'hf, RESP_OKAY);
      rd(ADDR_DECAY, 32'hfc);
      finish_test();
   end

   // hang guard, well above the roughly 1200 cycles the run needs
   initial
   begin
      repeat (30000) @(posedge aclk);
      errors++;
      finish_test();
   end
endmodule : agc_time_constant_regs_bench
